// >>> common/spg_defs.vh
/*
 * Constants for the shared-pin GPIO configuration block: register
 * indices, byte addresses, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
// Functional notes
// - Connection bit 1 attaches pin to its analog pad; 0 leaves it detached.
// - Bits 0..6 feed analog inputs three..nine; bit 7 feeds the common input.
// - Connection register sits at index 0x12 and resets to zero.
// - Direction bit 0 makes the pin an output; 1 makes it an input.
// - Direction register sits at index 0x13 and resets to zero (all outputs).
// - Direction bit n governs pin n alone.
// - Data register at index 0x14; bit 0 means low, 1 means high.
// - Writing data of an input pin updates only the register.
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH

// Register indices; byte address is four times the index
`define SPG_IDX_PAD_LINK   8'h12
`define SPG_IDX_DIRECTION  8'h13
`define SPG_IDX_PIN_VALUE  8'h14
`define SPG_ADDR_PAD_LINK  8'h48
`define SPG_ADDR_DIRECTION 8'h4C
`define SPG_ADDR_PIN_VALUE 8'h50

// Reset values
`define SPG_RST_PAD_LINK   8'h00
`define SPG_RST_DIRECTION  8'h00
`define SPG_RST_PIN_VALUE  8'h00

// Decoded register selects
`define SPG_SEL_NONE       2'h0
`define SPG_SEL_PAD_LINK   2'h1
`define SPG_SEL_DIRECTION  2'h2
`define SPG_SEL_PIN_VALUE  2'h3

// AXI responses
`define SPG_RESP_OKAY      2'h0
`define SPG_RESP_SLVERR    2'h2

`endif

// >>> core/spg_pin_sync.v
/*
 * Three-stage synchroniser for a group of pad inputs with a
 * stability filter: a new level is accepted once stages two and
 * three agree. Assumes the inputs are asynchronous to CLOCK.
 */
`timescale 1ns/10ps

module spg_pin_sync #(
    parameter WIDTH = 8
) (
    // Clock, reset, enable
    input  wire             clk,
    input  wire             srst,
    input  wire             ce,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    reg [WIDTH-1:0] stable_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (srst) begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                    stage3_reg[i] <= 1'b0;
                    stable_reg[i] <= 1'b0;
                end else if (ce) begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                    stage3_reg[i] <= stage2_reg[i];
                    // Stage one is never looked at here: metastability hazard
                    if (stage2_reg[i] == stage3_reg[i]) begin
                        stable_reg[i] <= stage3_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign sync_out = stable_reg;

endmodule // spg_pin_sync

// >>> core/spg_gpio.v
/*
 * Shared-pin GPIO configuration: pad-link, direction and pin-value
 * registers behind an AXI4-Lite slave, plus the pad drive logic.
 * Assumes pads are resolved outside (input, output, active-low
 * enable per pin) and analog switches follow ANALOG_PAD_LINK.
 */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "spg_defs.vh"

module spg_gpio #(
    parameter NPINS = 8
) (
    // Clock, reset, enable
    input  wire             CLOCK,
    input  wire             SRST,
    input  wire             CE,
    // AXI4-Lite write address
    input  wire             AWVALID,
    output wire             AWREADY,
    input  wire [7:0]       AWADDR,
    input  wire [2:0]       AWPROT,
    // AXI4-Lite write data
    input  wire             WVALID,
    output wire             WREADY,
    input  wire [31:0]      WDATA,
    input  wire [3:0]       WSTRB,
    // AXI4-Lite write response
    output wire             BVALID,
    input  wire             BREADY,
    output wire [1:0]       BRESP,
    // AXI4-Lite read address
    input  wire             ARVALID,
    output wire             ARREADY,
    input  wire [7:0]       ARADDR,
    input  wire [2:0]       ARPROT,
    // AXI4-Lite read data
    output wire             RVALID,
    input  wire             RREADY,
    output wire [31:0]      RDATA,
    output wire [1:0]       RRESP,
    // Pads
    input  wire [NPINS-1:0] PIN_IN,
    output wire [NPINS-1:0] PIN_OUT,
    output wire [NPINS-1:0] PIN_OE_N,
    // Analog switch controls: bits 0..6 to inputs three..nine, bit 7 to common
    output wire [NPINS-1:0] ANALOG_PAD_LINK
);

    // Byte address to register select; shared by both channels
    function [1:0] decode_sel;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'b00})
                `SPG_ADDR_PAD_LINK:  decode_sel = `SPG_SEL_PAD_LINK;
                `SPG_ADDR_DIRECTION: decode_sel = `SPG_SEL_DIRECTION;
                `SPG_ADDR_PIN_VALUE: decode_sel = `SPG_SEL_PIN_VALUE;
                default:             decode_sel = `SPG_SEL_NONE;
            endcase
        end
    endfunction

    // Configuration registers and registered pad drive
    reg  [NPINS-1:0] pad_link_reg;
    reg  [NPINS-1:0] pad_link_next;
    reg  [NPINS-1:0] pin_direction_reg;
    reg  [NPINS-1:0] pin_direction_next;
    reg  [NPINS-1:0] pin_value_reg;
    reg  [NPINS-1:0] pin_value_next;
    reg  [NPINS-1:0] pin_out_reg;
    reg  [NPINS-1:0] pin_oe_n_reg;
    reg  [NPINS-1:0] analog_link_reg;

    // Write channel state
    reg              aw_held_reg;
    reg  [1:0]       aw_sel_reg;
    reg              w_held_reg;
    reg  [7:0]       w_data_reg;
    reg              w_lane0_reg;
    reg              bvalid_reg;
    reg  [1:0]       bresp_reg;

    // Read channel state
    reg              rvalid_reg;
    reg  [31:0]      rdata_reg;
    reg  [1:0]       rresp_reg;

    wire [NPINS-1:0] pin_sync;
    wire             aw_take;
    wire             w_take;
    wire             ar_take;
    wire             do_write;
    wire [1:0]       ar_sel;
    wire [NPINS-1:0] value_read;

    spg_pin_sync #(
        .WIDTH    (NPINS)
    ) u_pin_sync (
        .clk      (CLOCK),
        .srst     (SRST),
        .ce       (CE),
        .async_in (PIN_IN),
        .sync_out (pin_sync)
    );

    // Each address/data side is taken once and held until the response
    assign AWREADY  = CE & ~aw_held_reg & ~bvalid_reg;
    assign WREADY   = CE & ~w_held_reg & ~bvalid_reg;
    assign ARREADY  = CE & ~rvalid_reg;
    assign aw_take  = AWVALID & AWREADY;
    assign w_take   = WVALID & WREADY;
    assign ar_take  = ARVALID & ARREADY;
    assign do_write = CE & aw_held_reg & w_held_reg & ~bvalid_reg;
    assign ar_sel   = decode_sel(ARADDR);

    // Linked input pins read the pad; output pins and unlinked pins read zero
    assign value_read = pin_direction_reg & pad_link_reg & pin_sync;

    always @* begin
        pad_link_next      = pad_link_reg;
        pin_direction_next = pin_direction_reg;
        pin_value_next     = pin_value_reg;
        // Lane 0 carries all eight bits; other lanes are ignored
        if (do_write && w_lane0_reg) begin
            case (aw_sel_reg)
                `SPG_SEL_PAD_LINK:  pad_link_next = w_data_reg;
                `SPG_SEL_DIRECTION: pin_direction_next = w_data_reg;
                `SPG_SEL_PIN_VALUE: pin_value_next = w_data_reg;
                default:            pad_link_next = pad_link_reg;
            endcase
        end
    end

    always @(posedge CLOCK) begin
        if (SRST) begin
            pad_link_reg      <= `SPG_RST_PAD_LINK;
            pin_direction_reg <= `SPG_RST_DIRECTION;
            pin_value_reg     <= `SPG_RST_PIN_VALUE;
        end else if (CE) begin
            pad_link_reg      <= pad_link_next;
            pin_direction_reg <= pin_direction_next;
            pin_value_reg     <= pin_value_next;
        end
    end

    // Pad drive, one independent slice per pin
    genvar i;
    generate
        for (i = 0; i < NPINS; i = i + 1) begin : g_pad
            always @(posedge CLOCK) begin
                if (SRST) begin
                    pin_out_reg[i]     <= 1'b0;
                    pin_oe_n_reg[i]    <= 1'b1;
                    analog_link_reg[i] <= 1'b0;
                end else if (CE) begin
                    analog_link_reg[i] <= pad_link_reg[i];
                    // Input pins never see the stored value on the pad
                    pin_out_reg[i]     <= pin_value_reg[i];
                    pin_oe_n_reg[i]    <= ~(pad_link_reg[i]
                                            & ~pin_direction_reg[i]);
                end
            end
        end
    endgenerate

    assign PIN_OUT         = pin_out_reg;
    assign PIN_OE_N        = pin_oe_n_reg;
    assign ANALOG_PAD_LINK = analog_link_reg;

    // Write channel
    always @(posedge CLOCK) begin
        if (SRST) begin
            aw_held_reg <= 1'b0;
            aw_sel_reg  <= `SPG_SEL_NONE;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_lane0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `SPG_RESP_OKAY;
        end else if (CE) begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_sel_reg  <= decode_sel(AWADDR);
            end
            if (w_take) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= WDATA[7:0];
                w_lane0_reg <= WSTRB[0];
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (aw_sel_reg == `SPG_SEL_NONE) ?
                               `SPG_RESP_SLVERR : `SPG_RESP_OKAY;
            end else if (bvalid_reg && BREADY) begin
                bvalid_reg  <= 1'b0;
            end
        end
    end

    assign BVALID = bvalid_reg;
    assign BRESP  = bresp_reg;

    // Read channel
    always @(posedge CLOCK) begin
        if (SRST) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `SPG_RESP_OKAY;
        end else if (CE) begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= `SPG_RESP_OKAY;
                case (ar_sel)
                    `SPG_SEL_PAD_LINK:  rdata_reg <= {24'h000000, pad_link_reg};
                    `SPG_SEL_DIRECTION: rdata_reg <= {24'h000000, pin_direction_reg};
                    `SPG_SEL_PIN_VALUE: rdata_reg <= {24'h000000, value_read};
                    default: begin
                        rdata_reg <= 32'h00000000;
                        rresp_reg <= `SPG_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_reg && RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign RVALID = rvalid_reg;
    assign RDATA  = rdata_reg;
    assign RRESP  = rresp_reg;

endmodule // spg_gpio

// >>> bench/spg_gpio_monitor.sv
/* Bus and pad checker for spg_gpio, bound to its top module.
   Assumes CE stays high while a transfer is in flight. */
`timescale 1ns/10ps

module spg_gpio_monitor #(
    parameter NPINS = 8
) (
    // Clock, reset, enable
    input logic             CLOCK,
    input logic             SRST,
    input logic             CE,
    // Register bus
    input logic             AWVALID,
    input logic             AWREADY,
    input logic             WVALID,
    input logic             WREADY,
    input logic             BVALID,
    input logic             BREADY,
    input logic             ARVALID,
    input logic             ARREADY,
    input logic             RVALID,
    input logic             RREADY,
    input logic [31:0]      RDATA,
    // Pads
    input logic [NPINS-1:0] PIN_OE_N,
    input logic [NPINS-1:0] ANALOG_PAD_LINK
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    // Both halves taken, then one enabled cycle to commit
    sequence s_wr_taken;
        AWVALID && AWREADY && WVALID && WREADY ##1 CE;
    endsequence

    a_reset_pads: assert property (disable iff (1'b0) SRST && CE |=>
        ANALOG_PAD_LINK == '0 && PIN_OE_N == '1) else $error("pads not idle after reset");
    a_drive_linked: assert property (&(PIN_OE_N | ANALOG_PAD_LINK))
        else $error("pad driven while unlinked");
    a_ce_freeze: assert property (!CE |-> !AWREADY && !WREADY && !ARREADY)
        else $error("ready while disabled");
    a_b_blocks: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken during response");
    a_b_hold: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write response dropped");
    a_w_answer: assert property (s_wr_taken |=> BVALID)
        else $error("write response late");
    a_r_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data late");
    a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data not held");
    a_r_blocks: assert property (RVALID |-> !ARREADY)
        else $error("read taken during response");
    a_r_upper: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule // spg_gpio_monitor

bind spg_gpio spg_gpio_monitor #(.NPINS(NPINS)) i_mon (
    .CLOCK(CLOCK), .SRST(SRST), .CE(CE), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .PIN_OE_N(PIN_OE_N), .ANALOG_PAD_LINK(ANALOG_PAD_LINK)
);

// >>> bench/spg_gpio_test.sv
/* Self-checking bench for spg_gpio over its register bus.
   Assumes spg_defs.vh on the include path and the bound checker. */
`timescale 1ns/10ps
`include "spg_defs.vh"

module spg_gpio_test;
    logic        clock = '0, srst = '1, ce = '1, awvalid = '0, wvalid = '0;
    logic        bready = '0, arvalid = '0, rready = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = '0, araddr = '0, pin_in = '0, pin_out, pin_oe_n, pad_link;
    logic [7:0]  link, dir, val;
    logic [2:0]  awprot = '0, arprot = '0;
    logic [3:0]  wstrb = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0]  bresp, rresp;
    int          mismatches = 0, n_tests = 0;

    spg_gpio #(.NPINS(8)) i_dut (
        .CLOCK(clock), .SRST(srst), .CE(ce), .AWVALID(awvalid), .AWREADY(awready),
        .AWADDR(awaddr), .AWPROT(awprot), .WVALID(wvalid), .WREADY(wready),
        .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(arprot),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
        .ANALOG_PAD_LINK(pad_link)
    );

    always #4 clock = ~clock;

    function automatic logic [7:0] f_oe_n(input logic [7:0] l, d);
        return ~(l & ~d);
    endfunction

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // Readiness sampled at the falling edge, so the rising edge decides
    task automatic wr(input logic [7:0] a, d, input logic s, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge clock);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        awprot <= 3'($urandom);
        wdata <= ($urandom << 8) | d;
        wstrb <= 4'(($urandom << 1) | s);
        do begin
            @(negedge clock);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clock);
            if (aw) awvalid <= '0;
            if (w) wvalid <= '0;
        end while (!b);
        bready <= '0;
        chk("write resp", r, er);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, e, input logic [1:0] er);
        logic ar, rv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clock);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        arprot <= 3'($urandom);
        do begin
            @(negedge clock);
            ar = arvalid && arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ar) arvalid <= '0;
        end while (!rv);
        rready <= '0;
        chk(nm, d, {24'h0, e});
        chk("read resp", r, er);
    endtask

    task automatic pads;
        repeat (6) @(negedge clock);
        chk("pad link", pad_link, link);
        chk("pad enable", pin_oe_n, f_oe_n(link, dir));
        chk("pad drive", pin_out & ~pin_oe_n, val & link & ~dir);
        chk("pad level", pin_out, val);
        rchk("pin value", `SPG_ADDR_PIN_VALUE, dir & link & pin_in, `SPG_RESP_OKAY);
    endtask

    initial begin
        void'($urandom(32'h72A6));
        repeat (2) @(posedge clock);
        srst <= '0;
        {link, dir, val} = '0;
        pads;
        rchk("link", `SPG_ADDR_PAD_LINK, 8'h00, `SPG_RESP_OKAY);
        rchk("direction", `SPG_ADDR_DIRECTION, 8'h00, `SPG_RESP_OKAY);
        for (int i = 0; i < 28; i++) begin
            // Walking ones on link, then on direction, then random settings
            link = (i < 8) ? 8'h01 << i : (i < 16) ? 8'hFF : 8'($urandom);
            dir = (i < 8) ? 8'h00 : (i < 16) ? 8'h01 << (i - 8) : 8'($urandom);
            val = 8'($urandom);
            pin_in <= 8'($urandom);
            if (i == 12) begin
                ce <= '0;
                repeat (3) @(posedge clock);
                chk("ready frozen", {awready, wready, arready}, 3'h0);
                ce <= '1;
            end
            wr(`SPG_ADDR_PAD_LINK, link, 1'b1, `SPG_RESP_OKAY);
            wr(`SPG_ADDR_DIRECTION, dir, 1'b1, `SPG_RESP_OKAY);
            wr(`SPG_ADDR_PIN_VALUE, val, 1'b1, `SPG_RESP_OKAY);
            rchk("link", `SPG_ADDR_PAD_LINK, link, `SPG_RESP_OKAY);
            rchk("direction", `SPG_ADDR_DIRECTION, dir, `SPG_RESP_OKAY);
            pads;
        end
        wr(8'h54, 8'hA5, 1'b1, `SPG_RESP_SLVERR);
        wr(`SPG_ADDR_PAD_LINK, ~link, 1'b0, `SPG_RESP_OKAY);
        rchk("unmapped", 8'h54, 8'h00, `SPG_RESP_SLVERR);
        rchk("link kept", `SPG_ADDR_PAD_LINK, link, `SPG_RESP_OKAY);
        @(posedge clock);
        srst <= '1;
        repeat (2) @(posedge clock);
        srst <= '0;
        {link, dir, val} = '0;
        pads;
        rchk("link reset", `SPG_ADDR_PAD_LINK, 8'h00, `SPG_RESP_OKAY);
        rchk("direction reset", `SPG_ADDR_DIRECTION, 8'h00, `SPG_RESP_OKAY);
        summarize;
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        summarize;
    end
endmodule // spg_gpio_test
